// File: tlic_top.v
// two-level interrupt controller with power modes and AXI4-Lite registers
// Functional notes
// - secondary register bit 6 makes interval-timer interrupt high priority.
// - secondary register bit 5 makes supply-monitor interrupt high priority.
// - secondary register bit 4 makes SPI interrupt high priority.
// - secondary register bit 2 enables the interval-timer interrupt.
// - secondary register bit 1 enables the supply-monitor interrupt.
// - secondary register bit 0 enables the SPI interrupt.
// - a high-priority request may preempt a running low-priority routine.
// - same-cycle requests of both levels vector to the high one first.
// - a running routine is never preempted at its own level.
// - same-level ties follow the fixed polling order, supply monitor first.
// - on acceptance the core pushes its counter and loads the vector.
// - each source has its fixed vector address.
// - with watchdog select set, timeout interrupts instead of resetting.
// - watchdog interrupt is always high priority.
// - watchdog interrupt is taken even with global enable cleared.
// - watchdog interrupts only when its timeout period is above zero.
// - power-control bit 0 enters idle, bit 1 enters power-down.
// - idle stops the core clock, peripherals keep running, state retained.
// - idle ends on any enabled interrupt request or hardware reset.
// - power-down stops PLL and core; oscillator stops only if its bit set.
// - primary enable bit 7 gates all maskable sources globally.
// - interval-timer interrupt ends power-down and gets serviced.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`include "tlic_map.vh"
module tlic_top (
   input wire aclk,
   input wire aresetn,
   input wire [4:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire external0_pin,
   input wire external1_pin,
   input wire supply_monitor_request,
   input wire converter_request,
   input wire timer0_request,
   input wire timer1_request,
   input wire spi_request,
   input wire uart_request,
   input wire timer2_request,
   input wire interval_timer_request,
   input wire watchdog_timeout,
   output reg irq_valid,
   output reg [15:0] irq_vector,
   input wire irq_ack,
   input wire irq_return,
   output reg push_pc,
   output reg watchdog_reset_req,
   output wire core_clk_en,
   output wire periph_clk_en,
   output wire pll_en,
   output wire osc_en
);
   reg [7:0] primary_irq_enable;
   reg [7:0] primary_irq_prio;
   reg [7:0] secondary_irq_enable_priority;
   reg [1:0] power_control_reg;
   reg watchdog_irq_select;
   reg [3:0] watchdog_period;
   reg oscillator_powerdown_bit;
   reg watchdog_pending;
   reg high_active;
   reg low_active;
   reg offer_high;
   reg [3:0] offer_idx;
   reg aw_held;
   reg w_held;
   reg [4:0] aw_addr;
   reg [7:0] w_byte;
   reg w_lane0;
   wire [1:0] external_level;
   wire global_irq_enable;
   wire interval_timer_irq_en;
   wire supply_monitor_irq_en;
   wire spi_port_irq_en;
   wire [10:0] raw_req;
   wire [10:0] enabled_req;
   wire [10:0] is_high;
   wire found;
   wire found_high;
   wire [3:0] found_idx;
   wire [15:0] found_vec;
   wire do_write;
   wire idle_mode;
   wire powerdown_mode;
   wire wake_idle;
   wire wake_powerdown;
   wire [7:0] status_word;
   reg [31:0] next_rdata;
   reg next_rd_err;

   // pins come from outside the clock domain
   tlic_sync #(
      .WIDTH(2)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in({external1_pin, external0_pin}),
      .level_out(external_level)
   );

   assign global_irq_enable = primary_irq_enable[`TLIC_BIT_GLOBAL_EN];
   assign interval_timer_irq_en = secondary_irq_enable_priority[`TLIC_BIT_TIC_EN];
   assign supply_monitor_irq_en = secondary_irq_enable_priority[`TLIC_BIT_PSM_EN];
   assign spi_port_irq_en = secondary_irq_enable_priority[`TLIC_BIT_SPI_EN];

   assign raw_req[`TLIC_SRC_PSM] = supply_monitor_request;
   assign raw_req[`TLIC_SRC_WDG] = watchdog_pending;
   assign raw_req[`TLIC_SRC_EXT0] = external_level[0];
   assign raw_req[`TLIC_SRC_ADC] = converter_request;
   assign raw_req[`TLIC_SRC_TMR0] = timer0_request;
   assign raw_req[`TLIC_SRC_EXT1] = external_level[1];
   assign raw_req[`TLIC_SRC_TMR1] = timer1_request;
   assign raw_req[`TLIC_SRC_SPI] = spi_request;
   assign raw_req[`TLIC_SRC_UART] = uart_request;
   assign raw_req[`TLIC_SRC_TMR2] = timer2_request;
   assign raw_req[`TLIC_SRC_TIC] = interval_timer_request;

   // primary enable layout: 0 ext0, 1 tmr0, 2 ext1, 3 tmr1, 4 uart, 5 tmr2, 6 adc
   assign enabled_req[`TLIC_SRC_PSM] = raw_req[`TLIC_SRC_PSM] & supply_monitor_irq_en
      & global_irq_enable;
   // watchdog ignores the global gate so a hung program still gets it
   assign enabled_req[`TLIC_SRC_WDG] = raw_req[`TLIC_SRC_WDG];
   assign enabled_req[`TLIC_SRC_EXT0] = raw_req[`TLIC_SRC_EXT0] & primary_irq_enable[0]
      & global_irq_enable;
   assign enabled_req[`TLIC_SRC_ADC] = raw_req[`TLIC_SRC_ADC] & primary_irq_enable[6]
      & global_irq_enable;
   assign enabled_req[`TLIC_SRC_TMR0] = raw_req[`TLIC_SRC_TMR0] & primary_irq_enable[1]
      & global_irq_enable;
   assign enabled_req[`TLIC_SRC_EXT1] = raw_req[`TLIC_SRC_EXT1] & primary_irq_enable[2]
      & global_irq_enable;
   assign enabled_req[`TLIC_SRC_TMR1] = raw_req[`TLIC_SRC_TMR1] & primary_irq_enable[3]
      & global_irq_enable;
   assign enabled_req[`TLIC_SRC_SPI] = raw_req[`TLIC_SRC_SPI] & spi_port_irq_en
      & global_irq_enable;
   assign enabled_req[`TLIC_SRC_UART] = raw_req[`TLIC_SRC_UART] & primary_irq_enable[4]
      & global_irq_enable;
   assign enabled_req[`TLIC_SRC_TMR2] = raw_req[`TLIC_SRC_TMR2] & primary_irq_enable[5]
      & global_irq_enable;
   assign enabled_req[`TLIC_SRC_TIC] = raw_req[`TLIC_SRC_TIC] & interval_timer_irq_en
      & global_irq_enable;

   // primary priority layout matches the primary enable layout
   assign is_high[`TLIC_SRC_PSM] = secondary_irq_enable_priority[`TLIC_BIT_PSM_PRIO];
   assign is_high[`TLIC_SRC_WDG] = 1'b1;
   assign is_high[`TLIC_SRC_EXT0] = primary_irq_prio[0];
   assign is_high[`TLIC_SRC_ADC] = primary_irq_prio[6];
   assign is_high[`TLIC_SRC_TMR0] = primary_irq_prio[1];
   assign is_high[`TLIC_SRC_EXT1] = primary_irq_prio[2];
   assign is_high[`TLIC_SRC_TMR1] = primary_irq_prio[3];
   assign is_high[`TLIC_SRC_SPI] = secondary_irq_enable_priority[`TLIC_BIT_SPI_PRIO];
   assign is_high[`TLIC_SRC_UART] = primary_irq_prio[4];
   assign is_high[`TLIC_SRC_TMR2] = primary_irq_prio[5];
   assign is_high[`TLIC_SRC_TIC] = secondary_irq_enable_priority[`TLIC_BIT_TIC_PRIO];

   tlic_arbiter u_arb (
      .req(enabled_req),
      .is_high(is_high),
      .high_busy(high_active),
      .low_busy(low_active),
      .found(found),
      .found_high(found_high),
      .found_idx(found_idx),
      .found_vec(found_vec)
   );

   // power modes
   assign idle_mode = power_control_reg[`TLIC_BIT_IDLE];
   assign powerdown_mode = power_control_reg[`TLIC_BIT_PDOWN];
   assign wake_idle = |enabled_req;
   assign wake_powerdown = enabled_req[`TLIC_SRC_TIC];
   // core halts in either mode; its state stays put since only its enable drops
   assign core_clk_en = !idle_mode && !powerdown_mode;
   assign periph_clk_en = !powerdown_mode;
   assign pll_en = !powerdown_mode;
   // interval timer runs from the oscillator, so it survives power-down unless the oscillator bit is set
   assign osc_en = !(powerdown_mode && oscillator_powerdown_bit);

   // vector offer to the core; held stale one cycle would double-take, so ack drops it
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_valid <= 1'b0;
         irq_vector <= 16'h0000;
         offer_high <= 1'b0;
         offer_idx <= 4'h0;
         push_pc <= 1'b0;
         high_active <= 1'b0;
         low_active <= 1'b0;
      end else begin
         push_pc <= irq_valid && irq_ack;
         // return closes the innermost level first; a take in the same cycle wins
         if (irq_return) begin
            if (high_active) begin
               high_active <= 1'b0;
            end else begin
               low_active <= 1'b0;
            end
         end
         if (irq_valid && irq_ack) begin
            irq_valid <= 1'b0;
            if (offer_high) begin
               high_active <= 1'b1;
            end else begin
               low_active <= 1'b1;
            end
         end else begin
            irq_valid <= found && core_clk_en;
            irq_vector <= found_vec;
            offer_high <= found_high;
            offer_idx <= found_idx;
         end
      end
   end

   // watchdog event becomes a sticky request; a new timeout beats the ack clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_pending <= 1'b0;
         watchdog_reset_req <= 1'b0;
      end else begin
         watchdog_reset_req <= watchdog_timeout && !watchdog_irq_select;
         if (watchdog_timeout && watchdog_irq_select && (watchdog_period != 4'h0)) begin
            watchdog_pending <= 1'b1;
         end else if (irq_valid && irq_ack && (offer_idx == `TLIC_SRC_WDG)) begin
            watchdog_pending <= 1'b0;
         end
      end
   end

   // AXI4-Lite write: address and data taken in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid)
      && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 5'h00;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         aw_held <= do_write ? 1'b0 : (aw_held || (s_axi_awvalid && s_axi_awready));
         w_held <= do_write ? 1'b0 : (w_held || (s_axi_wvalid && s_axi_wready));
      end
   end

   wire [4:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [7:0] wr_byte = w_held ? w_byte : s_axi_wdata[7:0];
   wire wr_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];
   wire wr_mapped = (wr_addr[4:2] <= 3'd6) && (wr_addr[1:0] == 2'b00);
   wire wr_en = do_write && wr_lane0;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TLIC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // register writes; power bits set by software, cleared by a wake event
   always @(posedge aclk) begin
      if (!aresetn) begin
         primary_irq_enable <= `TLIC_RST_PRI_EN;
         primary_irq_prio <= `TLIC_RST_PRI_PRIO;
         secondary_irq_enable_priority <= `TLIC_RST_SEC_ENPR;
         power_control_reg <= 2'b00;
         watchdog_irq_select <= 1'b0;
         watchdog_period <= 4'h0;
         oscillator_powerdown_bit <= 1'b0;
      end else begin
         if (wr_en && wr_addr == `TLIC_OFS_PRI_EN) begin
            primary_irq_enable <= wr_byte;
         end
         if (wr_en && wr_addr == `TLIC_OFS_PRI_PRIO) begin
            primary_irq_prio <= wr_byte;
         end
         if (wr_en && wr_addr == `TLIC_OFS_SEC_ENPR) begin
            // reserved bit 3 kept at zero regardless of what is written
            secondary_irq_enable_priority <= wr_byte & `TLIC_SEC_WMASK;
         end
         if (wr_en && wr_addr == `TLIC_OFS_WDG_CFG) begin
            watchdog_irq_select <= wr_byte[`TLIC_BIT_WDG_SEL];
            watchdog_period <= wr_byte[7:4];
         end
         if (wr_en && wr_addr == `TLIC_OFS_PLL_CTRL) begin
            oscillator_powerdown_bit <= wr_byte[`TLIC_BIT_OSCILLATOR_POWERDOWN_BIT];
         end
         if (wr_en && wr_addr == `TLIC_OFS_PWR_CTRL) begin
            power_control_reg <= wr_byte[1:0];
         end else begin
            if (idle_mode && wake_idle) begin
               power_control_reg[`TLIC_BIT_IDLE] <= 1'b0;
            end
            if (powerdown_mode && wake_powerdown) begin
               power_control_reg[`TLIC_BIT_PDOWN] <= 1'b0;
            end
         end
      end
   end

   // status: service levels, current offer and watchdog pending flag
   assign status_word = {high_active, low_active, irq_valid, watchdog_pending,
      offer_idx};

   assign s_axi_arready = !s_axi_rvalid;

   always @* begin
      next_rdata = 32'h0000_0000;
      next_rd_err = 1'b0;
      case (s_axi_araddr)
         `TLIC_OFS_PRI_EN: next_rdata[7:0] = primary_irq_enable;
         `TLIC_OFS_PRI_PRIO: next_rdata[7:0] = primary_irq_prio;
         `TLIC_OFS_SEC_ENPR: next_rdata[7:0] = secondary_irq_enable_priority;
         `TLIC_OFS_PWR_CTRL: next_rdata[1:0] = power_control_reg;
         `TLIC_OFS_WDG_CFG: next_rdata[7:0] = {watchdog_period, 3'b000, watchdog_irq_select};
         `TLIC_OFS_PLL_CTRL: next_rdata[0] = oscillator_powerdown_bit;
         `TLIC_OFS_STATUS: next_rdata[15:0] = {irq_vector[7:0], status_word};
         default: next_rd_err = 1'b1;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TLIC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rd_err ? `TLIC_RESP_SLVERR : `TLIC_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// File: tlic_map.vh
// register map, field positions, reset values and vectors of the interrupt controller
`ifndef TLIC_MAP_VH
`define TLIC_MAP_VH
`define TLIC_OFS_PRI_EN 5'h00
`define TLIC_OFS_PRI_PRIO 5'h04
`define TLIC_OFS_SEC_ENPR 5'h08
`define TLIC_OFS_PWR_CTRL 5'h0C
`define TLIC_OFS_WDG_CFG 5'h10
`define TLIC_OFS_PLL_CTRL 5'h14
`define TLIC_OFS_STATUS 5'h18
`define TLIC_RST_PRI_EN 8'h00
`define TLIC_RST_PRI_PRIO 8'h00
`define TLIC_RST_SEC_ENPR 8'hA0
`define TLIC_SEC_WMASK 8'hF7
`define TLIC_BIT_GLOBAL_EN 7
`define TLIC_BIT_TIC_PRIO 6
`define TLIC_BIT_PSM_PRIO 5
`define TLIC_BIT_SPI_PRIO 4
`define TLIC_BIT_TIC_EN 2
`define TLIC_BIT_PSM_EN 1
`define TLIC_BIT_SPI_EN 0
`define TLIC_BIT_IDLE 0
`define TLIC_BIT_PDOWN 1
`define TLIC_BIT_WDG_SEL 0
`define TLIC_BIT_OSCILLATOR_POWERDOWN_BIT 0
`define TLIC_SRC_PSM 0
`define TLIC_SRC_WDG 1
`define TLIC_SRC_EXT0 2
`define TLIC_SRC_ADC 3
`define TLIC_SRC_TMR0 4
`define TLIC_SRC_EXT1 5
`define TLIC_SRC_TMR1 6
`define TLIC_SRC_SPI 7
`define TLIC_SRC_UART 8
`define TLIC_SRC_TMR2 9
`define TLIC_SRC_TIC 10
`define TLIC_NUM_SRC 11
`define TLIC_VEC_EXT0 16'h0003
`define TLIC_VEC_TMR0 16'h000B
`define TLIC_VEC_EXT1 16'h0013
`define TLIC_VEC_TMR1 16'h001B
`define TLIC_VEC_UART 16'h0023
`define TLIC_VEC_TMR2 16'h002B
`define TLIC_VEC_ADC 16'h0033
`define TLIC_VEC_SPI 16'h003B
`define TLIC_VEC_PSM 16'h0043
`define TLIC_VEC_TIC 16'h0053
`define TLIC_VEC_WDG 16'h005B
`define TLIC_RESP_OKAY 2'b00
`define TLIC_RESP_SLVERR 2'b10
`endif

// File: tlic_sync.v
// three-stage synchroniser for pin inputs, per bit
module tlic_sync #(
   parameter WIDTH = 2
) (
   input wire aclk,
   input wire aresetn,
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] level_out
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge aclk) begin
            if (!aresetn) begin
               stage1[i] <= 1'b0;
               stage2[i] <= 1'b0;
               stage3[i] <= 1'b0;
               level_out[i] <= 1'b0;
            end else begin
               stage1[i] <= pin_in[i];
               stage2[i] <= stage1[i];
               stage3[i] <= stage2[i];
               // change counts only once stages two and three agree
               if (stage2[i] == stage3[i]) begin
                  level_out[i] <= stage3[i];
               end
            end
         end
      end
   endgenerate
endmodule

// File: tlic_arbiter.v
// two-level fixed-order arbiter with vector lookup
`include "tlic_map.vh"
module tlic_arbiter (
   input wire [10:0] req,
   input wire [10:0] is_high,
   input wire high_busy,
   input wire low_busy,
   output reg found,
   output reg found_high,
   output reg [3:0] found_idx,
   output reg [15:0] found_vec
);
   reg [10:0] high_req;
   reg [10:0] low_req;
   integer k;
   always @* begin
      high_req = req & is_high;
      low_req = req & ~is_high;
      found = 1'b0;
      found_high = 1'b0;
      found_idx = 4'h0;
      // scan lowest rank first so the highest-ranked request overwrites
      for (k = 10; k >= 0; k = k - 1) begin
         if (low_req[k] && !high_busy && !low_busy) begin
            found = 1'b1;
            found_high = 1'b0;
            found_idx = k[3:0];
         end
      end
      // any high request beats low ones, even mid low service
      for (k = 10; k >= 0; k = k - 1) begin
         if (high_req[k] && !high_busy) begin
            found = 1'b1;
            found_high = 1'b1;
            found_idx = k[3:0];
         end
      end
      case (found_idx)
         4'd0: found_vec = `TLIC_VEC_PSM;
         4'd1: found_vec = `TLIC_VEC_WDG;
         4'd2: found_vec = `TLIC_VEC_EXT0;
         4'd3: found_vec = `TLIC_VEC_ADC;
         4'd4: found_vec = `TLIC_VEC_TMR0;
         4'd5: found_vec = `TLIC_VEC_EXT1;
         4'd6: found_vec = `TLIC_VEC_TMR1;
         4'd7: found_vec = `TLIC_VEC_SPI;
         4'd8: found_vec = `TLIC_VEC_UART;
         4'd9: found_vec = `TLIC_VEC_TMR2;
         4'd10: found_vec = `TLIC_VEC_TIC;
         default: found_vec = 16'h0000;
      endcase
   end
endmodule

// File: tlic_props.sv
// assertion checker for the controller's offer, push, watchdog-reset and clock-enable outputs
module tlic_props (
   input wire aclk,
   input wire aresetn,
   input wire irq_valid,
   input wire [15:0] irq_vector,
   input wire irq_ack,
   input wire push_pc,
   input wire watchdog_timeout,
   input wire watchdog_reset_req,
   input wire core_clk_en,
   input wire periph_clk_en,
   input wire pll_en,
   input wire osc_en
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_taken;
      irq_valid && irq_ack;
   endsequence
   sequence s_pushed;
      push_pc && !irq_valid ##1 !push_pc;
   endsequence
   // two off cycles: the offer register may still hold a value from before entry
   sequence s_core_off;
      !core_clk_en ##1 !core_clk_en;
   endsequence
   a_ack_push: assert property (s_taken |=> s_pushed)
      else $error("no push after accepted offer");
   a_push_cause: assert property (push_pc |-> $past(irq_valid) && $past(irq_ack))
      else $error("push without accepted offer");
   a_vec_legal: assert property (irq_valid |-> irq_vector inside {16'h0003, 16'h000B,
      16'h0013, 16'h001B, 16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h0043, 16'h0053,
      16'h005B}) else $error("illegal vector offered");
   a_wdg_reset: assert property (watchdog_reset_req |-> $past(watchdog_timeout))
      else $error("reset request without timeout");
   a_idle_quiet: assert property (s_core_off |-> !irq_valid)
      else $error("offer while core clock stopped");
   a_run_clocks: assert property (core_clk_en |-> periph_clk_en && pll_en && osc_en)
      else $error("clock off while core runs");
   a_pd_clocks: assert property (!pll_en |-> !core_clk_en && !periph_clk_en)
      else $error("clocks left on in power-down");
   a_oscillator_powerdown_bit: assert property (!osc_en |-> !pll_en)
      else $error("oscillator off outside power-down");
endmodule

// File: tlic_core_model.sv
// core model: acks offers after a set wait, loads pc with the taken vector on push, tracks nesting depth
module tlic_core_model (
   input wire aclk,
   input wire aresetn,
   input wire irq_valid,
   input wire [15:0] irq_vector,
   input wire push_pc,
   input wire [3:0] ack_wait,
   input wire ret_req,
   output reg irq_ack,
   output reg irq_return,
   output reg [15:0] pc,
   output reg [3:0] depth
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [3:0] waited;
   reg [15:0] taken_vec;
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_ack <= 1'b0;
         irq_return <= 1'b0;
         pc <= 16'h0000;
         depth <= 4'h0;
         waited <= 4'h0;
         taken_vec <= 16'h0000;
      end else begin
         irq_return <= ret_req;
         // ack is a single pulse so a withdrawn offer is never taken late
         irq_ack <= irq_valid && !irq_ack && waited >= ack_wait;
         waited <= (irq_valid && !irq_ack) ? waited + 4'h1 : 4'h0;
         if (irq_ack && irq_valid) begin
            taken_vec <= irq_vector;
         end
         if (push_pc) begin
            pc <= taken_vec;
         end
         depth <= depth + {3'b000, push_pc} - {3'b000, irq_return};
      end
   end
endmodule

// File: two_level_interrupt_controller_tb.sv
// self-checking bench for the two-level interrupt controller
`include "tlic_map.vh"
module two_level_interrupt_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, ret_req = 1'b0, wdt = 1'b0;
   logic [10:0] req = 11'h000;
   logic [3:0] ack_wait = 4'h0;
   wire awready, wready, bvalid, arready, rvalid, irq_valid, irq_ack, irq_return, push_pc;
   wire wd_rst, core_en, periph_en, pll_en, osc_en;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] irq_vector, pc;
   wire [3:0] depth;
   int errors = 0;
   int n_checks = 0;
   logic [15:0] vt [11] = '{`TLIC_VEC_PSM, `TLIC_VEC_WDG, `TLIC_VEC_EXT0, `TLIC_VEC_ADC,
      `TLIC_VEC_TMR0, `TLIC_VEC_EXT1, `TLIC_VEC_TMR1, `TLIC_VEC_SPI, `TLIC_VEC_UART,
      `TLIC_VEC_TMR2, `TLIC_VEC_TIC};
   always #5 aclk = ~aclk;
   tlic_top i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .external0_pin(req[2]), .external1_pin(req[5]), .supply_monitor_request(req[0]),
      .converter_request(req[3]), .timer0_request(req[4]), .timer1_request(req[6]),
      .spi_request(req[7]), .uart_request(req[8]), .timer2_request(req[9]),
      .interval_timer_request(req[10]), .watchdog_timeout(wdt), .irq_valid(irq_valid),
      .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return), .push_pc(push_pc),
      .watchdog_reset_req(wd_rst), .core_clk_en(core_en), .periph_clk_en(periph_en),
      .pll_en(pll_en), .osc_en(osc_en));
   tlic_core_model i_core (
      .aclk(aclk), .aresetn(aresetn), .irq_valid(irq_valid), .irq_vector(irq_vector),
      .push_pc(push_pc), .ack_wait(ack_wait), .ret_req(ret_req), .irq_ack(irq_ack),
      .irq_return(irq_return), .pc(pc), .depth(depth));
   task chk(input string name, input [31:0] seen, input [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // bready and rready stay high, which the bus allows at any time
   task wr(input [4:0] a, input [7:0] d);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk("bresp", {30'h0, bresp}, {30'h0, `TLIC_RESP_OKAY});
   endtask
   task rd(input [4:0] a, input [31:0] d, input [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk("rdata", rdata, d);
      chk("rresp", {30'h0, rresp}, {30'h0, r});
   endtask
   // hold=1 watches for a take that must not happen
   task see(input [3:0] d, input [15:0] v, input bit hold);
      for (int i = 0; i < 60 && (hold ? i < 20 : depth !== d); i++) @(posedge aclk);
      chk("depth_pc", {12'h000, depth, pc}, {12'h000, d, v});
   endtask
   task ret;
      logic [3:0] d0;
      d0 = depth;
      ret_req <= 1'b1;
      @(posedge aclk);
      ret_req <= 1'b0;
      for (int i = 0; i < 9 && depth === d0; i++) @(posedge aclk);
   endtask
   task pulse_wd;
      wdt <= 1'b1;
      @(posedge aclk);
      wdt <= 1'b0;
   endtask
   task clocks(input [3:0] e);
      @(posedge aclk);
      chk("clk_en", {28'h0, core_en, periph_en, pll_en, osc_en}, {28'h0, e});
   endtask
   task t_regs;
      rd(`TLIC_OFS_SEC_ENPR, 32'h0000_00A0, `TLIC_RESP_OKAY);
      wr(`TLIC_OFS_SEC_ENPR, 8'h77);
      rd(`TLIC_OFS_SEC_ENPR, 32'h0000_0077, `TLIC_RESP_OKAY);
      rd(5'h1C, 32'h0000_0000, `TLIC_RESP_SLVERR);
   endtask
   task t_poll;
      wr(`TLIC_OFS_SEC_ENPR, 8'h07);
      wr(`TLIC_OFS_PRI_EN, 8'h7F);
      req <= 11'h7FF;
      see(0, 16'h0000, 1);
      wr(`TLIC_OFS_PRI_EN, 8'hFF);
      for (int k = 0; k < 11; k++) begin
         if (k != 1) begin
            see(1, vt[k], 0);
            req[k] <= 1'b0;
            repeat (8) @(posedge aclk);
            ret;
         end
      end
   endtask
   task t_levels;
      ack_wait <= 4'h5;
      wr(`TLIC_OFS_SEC_ENPR, 8'h17);
      req <= 11'h480;
      see(1, `TLIC_VEC_SPI, 0);
      req[7] <= 1'b0;
      ret;
      see(1, `TLIC_VEC_TIC, 0);
      req[8] <= 1'b1;
      see(1, `TLIC_VEC_TIC, 1);
      req[7] <= 1'b1;
      see(2, `TLIC_VEC_SPI, 0);
      req[7] <= 1'b0;
      ret;
      see(1, `TLIC_VEC_SPI, 1);
      req[10] <= 1'b0;
      ret;
      see(1, `TLIC_VEC_UART, 0);
      req[8] <= 1'b0;
      ret;
   endtask
   task t_wdg;
      ack_wait <= 4'h0;
      wr(`TLIC_OFS_PRI_EN, 8'h10);
      wr(`TLIC_OFS_WDG_CFG, 8'h01);
      req[8] <= 1'b1;
      pulse_wd;
      see(0, `TLIC_VEC_UART, 1);
      wr(`TLIC_OFS_WDG_CFG, 8'hF1);
      pulse_wd;
      see(1, `TLIC_VEC_WDG, 0);
      req[8] <= 1'b0;
      ret;
      wr(`TLIC_OFS_WDG_CFG, 8'hF0);
      pulse_wd;
      @(posedge aclk);
      chk("wdg_reset", {31'h0, wd_rst}, 32'h0000_0001);
      see(0, `TLIC_VEC_WDG, 1);
   endtask
   task t_power;
      wr(`TLIC_OFS_PRI_EN, 8'h80);
      wr(`TLIC_OFS_SEC_ENPR, 8'h04);
      wr(`TLIC_OFS_PWR_CTRL, 8'h01);
      clocks(4'h7);
      req[10] <= 1'b1;
      see(1, `TLIC_VEC_TIC, 0);
      clocks(4'hF);
      req[10] <= 1'b0;
      ret;
      wr(`TLIC_OFS_PLL_CTRL, 8'h01);
      wr(`TLIC_OFS_PWR_CTRL, 8'h02);
      clocks(4'h0);
      req[10] <= 1'b1;
      see(1, `TLIC_VEC_TIC, 0);
      req[10] <= 1'b0;
      ret;
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_poll;
      t_levels;
      t_wdg;
      t_power;
      end_of_test;
   end
   initial begin
      #100000;
      errors = errors + 1;
      end_of_test;
   end
endmodule
bind tlic_top tlic_props i_props (.aclk(aclk), .aresetn(aresetn), .irq_valid(irq_valid),
   .irq_vector(irq_vector), .irq_ack(irq_ack), .push_pc(push_pc),
   .watchdog_timeout(watchdog_timeout), .watchdog_reset_req(watchdog_reset_req),
   .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .pll_en(pll_en), .osc_en(osc_en));
